// [udt_baud.sv]
// package of shared constants and the bit-rate divider of the transmitter
package udt_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned MAX_BPS       = 1_000_000;
  // fastest allowed bit cell, in clock cycles (cell length rounds down, so the top rate rounds up)
  localparam int unsigned MIN_DIV       = CLK_HZ / MAX_BPS;
  localparam logic [15:0] DIV_RESET     = 16'h0056;
  localparam logic [11:0] OFF_START     = 12'h000;
  localparam logic [11:0] OFF_STOP      = 12'h004;
  localparam logic [11:0] OFF_EV_SENT   = 12'h010;
  localparam logic [11:0] OFF_EV_DONE   = 12'h014;
  localparam logic [11:0] OFF_EV_HALT   = 12'h018;
  localparam logic [11:0] OFF_EV_LATCH  = 12'h01C;
  localparam logic [11:0] OFF_CONFIG    = 12'h020;
  localparam logic [11:0] OFF_BAUD      = 12'h024;
  localparam logic [11:0] OFF_PTR       = 12'h028;
  localparam logic [11:0] OFF_MAXCNT    = 12'h02C;
  localparam logic [11:0] OFF_AMOUNT    = 12'h030;
  localparam logic [11:0] OFF_STATUS    = 12'h034;
  localparam int unsigned CFG_FCE       = 0;
  localparam int unsigned CFG_PARITY    = 1;
  localparam int unsigned CFG_TWO_STOP  = 2;
  localparam logic [2:0]  CFG_RESET     = 3'h0;
  localparam logic [3:0]  FRAME_BASE    = 4'hA;
endpackage

`timescale 1ns/10ps
module udt_baud (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] div_eff;
  // saturating gap since the last tick; feeds only the rate check
  logic [15:0] since_tick;
  logic [15:0] next_since_tick;

  // clamp keeps the line at or below the top rate
  assign div_eff = (div < 16'(udt_pkg::MIN_DIV)) ? 16'(udt_pkg::MIN_DIV) : div;
  assign tick    = run && (count == div_eff - 16'h0001);

  always_comb begin
    if (!run || tick) begin
      next_count = 16'h0000;
    end else begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  always_comb begin
    if (tick) begin
      next_since_tick = 16'h0000;
    end else if (since_tick != 16'hFFFF) begin
      next_since_tick = since_tick + 16'h0001;
    end else begin
      next_since_tick = since_tick;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_tick <= 16'hFFFF;
    end else begin
      since_tick <= next_since_tick;
    end
  end

  property p_min_cell;
    @(posedge mclk) disable iff (!rst_n) tick |-> since_tick >= 16'(udt_pkg::MIN_DIV - 1);
  endproperty
  a_min_cell: assert property (p_min_cell) else $error("bit cell shorter than the fastest rate");
endmodule

// [udt_tx.sv]
// dma-fed asynchronous serial transmitter with apb registers
// Function
// - line rates up to 1 Mbps from divider
// - optional even parity, one or two stops
// - data bits leave least significant first
// - pointer and count latched, rewritable after latch
// - done only after last memory access
// - start latches pointer and count and begins sending
// - one byte-sent pulse per finished character
// - count reached ends transfer with done
// - stop halts, then halted event
// - stop before done still raises done
// - flow control pauses and resumes on cts
// - character in flight finishes before pause
// - divider idle before start and after halt
// - clear-to-send is active low
// - flow control off ignores clear-to-send
// - parity is even over data bits
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module udt_tx #(
  parameter int CW = 16
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               dma_req,
  output logic [31:0]        dma_addr,
  input  wire logic          dma_ack,
  input  wire logic [7:0]    dma_rdata,
  input  wire logic          cts_n,
  output logic               txd,
  output logic               tx_byte_sent_event,
  output logic               tx_buffer_done_event,
  output logic               tx_halted_event,
  output logic               tx_buffer_latched_event
);
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_SHIFT, ST_DONE, ST_HALT} udt_state_t;

  udt_state_t  st, next_st;
  logic [31:0] tx_buffer_pointer, next_ptr, base, next_base;
  logic [CW-1:0] tx_byte_count_limit, next_lim, cnt, next_cnt, sent, next_sent;
  logic [2:0]  cfg, next_cfg;
  logic [15:0] div, next_div;
  logic [3:0]  evf, next_evf;
  logic [31:0] next_prdata;
  logic [11:0] sh, next_sh;
  logic [7:0]  chr, next_chr;
  logic [3:0]  bit_idx, next_bit_idx, nbits;
  logic        stop_req, next_stop_req, next_txd, next_sent_ev, next_latch_ev;
  logic        cts_m, cts_s, cts_ok, tick, wr, rd_setup, start_pulse, stop_pulse, mapped;

  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign start_pulse = wr && paddr == udt_pkg::OFF_START && pwdata[0];
  assign stop_pulse  = wr && paddr == udt_pkg::OFF_STOP && pwdata[0];
  assign mapped  = paddr inside {udt_pkg::OFF_START, udt_pkg::OFF_STOP, udt_pkg::OFF_EV_SENT, udt_pkg::OFF_EV_DONE,
                                 udt_pkg::OFF_EV_HALT, udt_pkg::OFF_EV_LATCH, udt_pkg::OFF_CONFIG, udt_pkg::OFF_BAUD,
                                 udt_pkg::OFF_PTR, udt_pkg::OFF_MAXCNT, udt_pkg::OFF_AMOUNT, udt_pkg::OFF_STATUS};
  assign pslverr = psel && penable && !mapped;

  // cts is a pin: two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts_m <= 1'b1;
      cts_s <= 1'b1;
    end else begin
      cts_m <= cts_n;
      cts_s <= cts_m;
    end
  end
  assign cts_ok = !cfg[udt_pkg::CFG_FCE] || !cts_s;

  // baud divider only runs while shifting, so idle costs no toggling
  udt_baud u_baud (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run   (st == ST_SHIFT),
    .div   (div),
    .tick  (tick)
  );

  assign nbits = udt_pkg::FRAME_BASE + {3'h0, cfg[udt_pkg::CFG_PARITY]} + {3'h0, cfg[udt_pkg::CFG_TWO_STOP]};
  assign dma_req  = (st == ST_FETCH);
  assign dma_addr = base + 32'(sent);
  assign tx_buffer_done_event = (st == ST_DONE);
  assign tx_halted_event      = (st == ST_HALT);

  always_comb begin
    next_st       = st;
    next_base     = base;
    next_cnt      = cnt;
    next_sent     = sent;
    next_sh       = sh;
    next_chr      = chr;
    next_bit_idx  = bit_idx;
    next_stop_req = stop_req || (stop_pulse && st != ST_IDLE);
    next_sent_ev  = 1'b0;
    next_latch_ev = 1'b0;
    unique case (st)
      ST_IDLE: begin
        if (stop_pulse) begin
          next_st = ST_HALT;
        end else if (start_pulse) begin
          next_base     = tx_buffer_pointer;
          next_cnt      = tx_byte_count_limit;
          next_sent     = '0;
          next_latch_ev = 1'b1;
          next_st       = (tx_byte_count_limit == '0) ? ST_DONE : ST_FETCH;
        end
      end
      ST_FETCH: begin
        // a fetch in flight is completed even under stop
        if (dma_ack) begin
          next_chr = dma_rdata;
          next_st  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (next_stop_req) begin
          next_st = ST_DONE;
        end else if (cts_ok) begin
          next_sh      = {2'b11, cfg[udt_pkg::CFG_PARITY] ? ^chr : 1'b1, chr, 1'b0};
          next_bit_idx = 4'h0;
          next_st      = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // cts is not looked at here: the character always completes
        if (tick) begin
          next_sh      = {1'b1, sh[11:1]};
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx == nbits - 4'h1) begin
            next_sent_ev = 1'b1;
            next_sent    = sent + CW'(1);
            next_st      = (next_stop_req || sent + CW'(1) == cnt) ? ST_DONE : ST_FETCH;
          end
        end
      end
      ST_DONE: begin
        // a stop landing in this very cycle must not linger into idle
        next_st = next_stop_req ? ST_HALT : ST_IDLE;
      end
      ST_HALT: begin
        next_st       = ST_IDLE;
        next_stop_req = 1'b0;
      end
    endcase
    next_txd = (next_st == ST_SHIFT) ? next_sh[0] : 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= ST_IDLE;
      base     <= 32'h0000_0000;
      cnt      <= '0;
      sent     <= '0;
      sh       <= 12'hFFF;
      chr      <= 8'h00;
      bit_idx  <= 4'h0;
      stop_req <= 1'b0;
      txd      <= 1'b1;
      tx_byte_sent_event      <= 1'b0;
      tx_buffer_latched_event <= 1'b0;
    end else begin
      st       <= next_st;
      base     <= next_base;
      cnt      <= next_cnt;
      sent     <= next_sent;
      sh       <= next_sh;
      chr      <= next_chr;
      bit_idx  <= next_bit_idx;
      stop_req <= next_stop_req;
      txd      <= next_txd;
      tx_byte_sent_event      <= next_sent_ev;
      tx_buffer_latched_event <= next_latch_ev;
    end
  end

  // register file; read data captured in the setup cycle
  always_comb begin
    next_ptr = tx_buffer_pointer;
    next_lim = tx_byte_count_limit;
    next_cfg = cfg;
    next_div = div;
    next_evf = evf;
    next_prdata = prdata;
    if (wr) begin
      unique case (paddr)
        udt_pkg::OFF_PTR:      next_ptr = pwdata;
        udt_pkg::OFF_MAXCNT:   next_lim = pwdata[CW-1:0];
        udt_pkg::OFF_CONFIG:   next_cfg = pwdata[2:0];
        udt_pkg::OFF_BAUD:     next_div = pwdata[15:0];
        udt_pkg::OFF_EV_SENT:  next_evf[0] = next_evf[0] & pwdata[0];
        udt_pkg::OFF_EV_DONE:  next_evf[1] = next_evf[1] & pwdata[0];
        udt_pkg::OFF_EV_HALT:  next_evf[2] = next_evf[2] & pwdata[0];
        udt_pkg::OFF_EV_LATCH: next_evf[3] = next_evf[3] & pwdata[0];
        default: begin
        end
      endcase
    end
    // a set in the clearing cycle wins
    next_evf = next_evf | {tx_buffer_latched_event, tx_halted_event, tx_buffer_done_event, tx_byte_sent_event};
    if (rd_setup) begin
      unique case (paddr)
        udt_pkg::OFF_EV_SENT:  next_prdata = {31'h0, evf[0]};
        udt_pkg::OFF_EV_DONE:  next_prdata = {31'h0, evf[1]};
        udt_pkg::OFF_EV_HALT:  next_prdata = {31'h0, evf[2]};
        udt_pkg::OFF_EV_LATCH: next_prdata = {31'h0, evf[3]};
        udt_pkg::OFF_CONFIG:   next_prdata = {29'h0, cfg};
        udt_pkg::OFF_BAUD:     next_prdata = {16'h0, div};
        udt_pkg::OFF_PTR:      next_prdata = tx_buffer_pointer;
        udt_pkg::OFF_MAXCNT:   next_prdata = 32'(tx_byte_count_limit);
        udt_pkg::OFF_AMOUNT:   next_prdata = 32'(sent);
        udt_pkg::OFF_STATUS:   next_prdata = {30'h0, st == ST_WAIT && !cts_ok, st != ST_IDLE};
        default:               next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_pointer   <= 32'h0000_0000;
      tx_byte_count_limit <= '0;
      cfg    <= udt_pkg::CFG_RESET;
      div    <= udt_pkg::DIV_RESET;
      evf    <= 4'h0;
      prdata <= 32'h0000_0000;
    end else begin
      tx_buffer_pointer   <= next_ptr;
      tx_byte_count_limit <= next_lim;
      cfg    <= next_cfg;
      div    <= next_div;
      evf    <= next_evf;
      prdata <= next_prdata;
    end
  end

  property p_idle_high;
    @(posedge mclk) disable iff (!rst_n) st != ST_SHIFT |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high outside a frame");
  property p_start_low;
    @(posedge mclk) disable iff (!rst_n) st == ST_SHIFT && bit_idx == 4'h0 |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_lsb_first;
    @(posedge mclk) disable iff (!rst_n) st == ST_SHIFT && bit_idx == 4'h1 |-> txd == chr[0];
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit is not bit 0");
  property p_even_parity;
    @(posedge mclk) disable iff (!rst_n)
      st == ST_SHIFT && bit_idx == 4'h9 && cfg[udt_pkg::CFG_PARITY] |-> txd == ^chr;
  endproperty
  a_even_parity: assert property (p_even_parity) else $error("parity bit not even");
  property p_sent_once;
    @(posedge mclk) disable iff (!rst_n) tx_byte_sent_event |=> !tx_byte_sent_event;
  endproperty
  a_sent_once: assert property (p_sent_once) else $error("byte-sent pulse longer than one cycle");
  property p_stop_idle;
    @(posedge mclk) disable iff (!rst_n) stop_pulse && st == ST_IDLE |=> tx_halted_event;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no halted event for stop while idle");
  property p_halt_after_done;
    @(posedge mclk) disable iff (!rst_n) tx_buffer_done_event && stop_req |=> tx_halted_event ##1 st == ST_IDLE;
  endproperty
  a_halt_after_done: assert property (p_halt_after_done) else $error("stop did not end in halted");
  property p_cts_pause;
    @(posedge mclk) disable iff (!rst_n) st == ST_WAIT && !cts_ok && !stop_pulse && !stop_req |=> st == ST_WAIT;
  endproperty
  a_cts_pause: assert property (p_cts_pause) else $error("frame started while cts inactive");
  property p_no_access_done;
    @(posedge mclk) disable iff (!rst_n) tx_buffer_done_event |-> !dma_req ##1 !dma_req;
  endproperty
  a_no_access_done: assert property (p_no_access_done) else $error("memory access after done");
  property p_latch;
    @(posedge mclk) disable iff (!rst_n) start_pulse && st == ST_IDLE && !stop_pulse |=> tx_buffer_latched_event
      && base == $past(tx_buffer_pointer);
  endproperty
  a_latch: assert property (p_latch) else $error("start did not latch the pointer");
  property p_addr_order;
    @(posedge mclk) disable iff (!rst_n) tx_byte_sent_event && st == ST_FETCH |-> dma_addr == $past(dma_addr) + 32'h0000_0001;
  endproperty
  a_addr_order: assert property (p_addr_order) else $error("fetch address not ascending");

  c_done:   cover property (@(posedge mclk) disable iff (!rst_n) tx_buffer_done_event && !stop_req);
  c_stop:   cover property (@(posedge mclk) disable iff (!rst_n) tx_buffer_done_event && stop_req && sent != cnt);
  c_pause:  cover property (@(posedge mclk) disable iff (!rst_n) st == ST_WAIT && !cts_ok ##1 st == ST_WAIT && cts_ok
                            ##1 st == ST_SHIFT);
  c_parity: cover property (@(posedge mclk) disable iff (!rst_n) tx_byte_sent_event && cfg == 3'h6);
endmodule

// [udt_remote.sv]
// far-end serial receiver with clear-to-send output, used as the bench partner
`timescale 1ns/10ps
module udt_remote (
  input  wire logic        mclk,
  input  wire logic        txd,
  input  wire logic [15:0] div,
  input  wire logic        par_en,
  input  wire logic        two_stop,
  input  wire logic        hold,
  output logic             cts_n,
  output logic [7:0]       rx_cnt,
  output logic             rx_err
);
  logic [7:0] rx_mem [0:255];
  logic [7:0] sh;
  int         i;

  // low lets the far end send, high asks it to pause
  assign cts_n = hold;

  initial begin
    rx_cnt = 8'h00;
    rx_err = 1'b0;
    sh     = 8'h00;
    forever begin
      @(negedge txd);
      // sample mid-cell so small edge skew cannot fool us
      repeat (div / 2) @(posedge mclk);
      if (txd !== 1'b0) rx_err = 1'b1;
      for (i = 0; i < 8; i++) begin
        repeat (div) @(posedge mclk);
        sh[i] = txd;
      end
      if (par_en) begin
        repeat (div) @(posedge mclk);
        if (txd !== ^sh) rx_err = 1'b1;
      end
      repeat (div) @(posedge mclk);
      if (txd !== 1'b1) rx_err = 1'b1;
      if (two_stop) begin
        repeat (div) @(posedge mclk);
        if (txd !== 1'b1) rx_err = 1'b1;
      end
      rx_mem[rx_cnt] = sh;
      rx_cnt = rx_cnt + 8'h01;
    end
  end
endmodule

// [udt_tx_bench.sv]
// self-checking bench for the dma-fed serial transmitter
`timescale 1ns/10ps
`define UDT_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module udt_tx_bench;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, dma_req, cts_n, txd, hold;
  logic        e_sent, e_done, e_halt, e_latch, rx_err, par_en, two_stop, err;
  logic        dma_ack   = 1'b0;
  logic [7:0]  dma_rdata = 8'h00;
  logic [7:0]  rx_cnt, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dma_addr, rd;
  int          failures, num_checks, cyc, i;
  int          ev[4]   = '{0, 0, 0, 0};
  int          last[4] = '{0, 0, 0, 0};

  udt_tx dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .cts_n(cts_n), .txd(txd), .tx_byte_sent_event(e_sent), .tx_buffer_done_event(e_done),
    .tx_halted_event(e_halt), .tx_buffer_latched_event(e_latch));
  udt_remote rem (.mclk(mclk), .txd(txd), .div(16'h000A), .par_en(par_en), .two_stop(two_stop),
    .hold(hold), .cts_n(cts_n), .rx_cnt(rx_cnt), .rx_err(rx_err));

  always #50 mclk = ~mclk;

  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // one-cycle memory; data line scrambles when not answering
  always @(posedge mclk) begin
    if (dma_req === 1'b1 && dma_ack === 1'b0) begin
      dma_ack   <= 1'b1;
      dma_rdata <= mem_byte(dma_addr);
    end else begin
      dma_ack   <= 1'b0;
      dma_rdata <= ~dma_rdata;
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (e_sent === 1'b1) ev[0] <= ev[0] + 1;
    if (e_done === 1'b1) begin ev[1] <= ev[1] + 1; last[1] <= cyc; end
    if (e_halt === 1'b1) begin ev[2] <= ev[2] + 1; last[2] <= cyc; end
    if (e_latch === 1'b1) ev[3] <= ev[3] + 1;
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_ev(input int k, input int tgt);
    for (int j = 0; j < 5000 && ev[k] < tgt; j++) @(posedge mclk);
  endtask

  task automatic xfer(input logic [31:0] p, input logic [31:0] n);
    b = rx_cnt;
    apb(1'b1, udt_pkg::OFF_PTR, p);
    apb(1'b1, udt_pkg::OFF_MAXCNT, n);
    apb(1'b1, udt_pkg::OFF_START, 32'h1);
  endtask

  task automatic chk_bytes(input logic [7:0] base, input logic [31:0] p, input int n);
    for (i = 0; i < n; i++) `UDT_CHK("rx byte", mem_byte(p + i), rem.rx_mem[8'(base + i)])
    `UDT_CHK("rx count", 8'(base + n), rx_cnt)
    `UDT_CHK("rx error", 1'b0, rx_err)
  endtask

  task automatic t_regs;
    apb(1'b0, udt_pkg::OFF_CONFIG, 32'h0);
    `UDT_CHK("config reset", 32'h0, rd)
    apb(1'b0, udt_pkg::OFF_BAUD, 32'h0);
    `UDT_CHK("baud reset", {16'h0000, udt_pkg::DIV_RESET}, rd)
    apb(1'b0, 12'hFFC, 32'h0);
    `UDT_CHK("unmapped err", 1'b1, err)
    `UDT_CHK("unmapped data", 32'h0, rd)
    `UDT_CHK("pready", 1'b1, pready)
    $display("test regs done");
  endtask

  task automatic t_basic;
    int s, l, d;
    s = ev[0]; l = ev[3];
    apb(1'b1, udt_pkg::OFF_BAUD, 32'h5);
    xfer(32'h20, 32'h3);
    wait_ev(1, ev[1] + 1);
    chk_bytes(b, 32'h20, 3);
    `UDT_CHK("sent events", s + 3, ev[0])
    `UDT_CHK("latch events", l + 1, ev[3])
    apb(1'b0, udt_pkg::OFF_AMOUNT, 32'h0);
    `UDT_CHK("amount", 32'h3, rd)
    apb(1'b0, udt_pkg::OFF_EV_DONE, 32'h0);
    `UDT_CHK("done flag", 32'h1, rd)
    apb(1'b1, udt_pkg::OFF_EV_DONE, 32'h0);
    apb(1'b0, udt_pkg::OFF_EV_DONE, 32'h0);
    `UDT_CHK("done flag cleared", 32'h0, rd)
    d = ev[1];
    xfer(32'h20, 32'h0);
    wait_ev(1, d + 1);
    `UDT_CHK("empty done", d + 1, ev[1])
    `UDT_CHK("empty transfer", b, rx_cnt)
    `UDT_CHK("empty sent", s + 3, ev[0])
    $display("test basic done");
  endtask

  task automatic t_parity;
    par_en <= 1'b1; two_stop <= 1'b1;
    apb(1'b1, udt_pkg::OFF_CONFIG, 32'h6);
    xfer(32'h40, 32'h2);
    wait_ev(1, ev[1] + 1);
    chk_bytes(b, 32'h40, 2);
    par_en <= 1'b0; two_stop <= 1'b0;
    apb(1'b1, udt_pkg::OFF_CONFIG, 32'h0);
    $display("test parity done");
  endtask

  task automatic t_dbuf;
    int d;
    d = ev[1];
    xfer(32'h60, 32'h4);
    wait_ev(3, ev[3] + 1);
    apb(1'b1, udt_pkg::OFF_PTR, 32'h80);
    apb(1'b1, udt_pkg::OFF_MAXCNT, 32'h1);
    wait_ev(1, d + 1);
    chk_bytes(b, 32'h60, 4);
    apb(1'b1, udt_pkg::OFF_START, 32'h1);
    wait_ev(1, d + 2);
    chk_bytes(8'(b + 4), 32'h80, 1);
    $display("test double buffer done");
  endtask

  task automatic t_stop;
    int d, h;
    d = ev[1]; h = ev[2];
    xfer(32'h90, 32'h8);
    wait_ev(0, ev[0] + 1);
    apb(1'b1, udt_pkg::OFF_STOP, 32'h1);
    wait_ev(2, h + 1);
    `UDT_CHK("done on stop", d + 1, ev[1])
    `UDT_CHK("done before halt", 1'b1, last[1] < last[2])
    `UDT_CHK("short transfer", 1'b1, 8'(rx_cnt - b) < 8'h08)
    apb(1'b0, udt_pkg::OFF_AMOUNT, 32'h0);
    `UDT_CHK("amount on stop", {24'h0, 8'(rx_cnt - b)}, rd)
    `UDT_CHK("no fetch after done", 1'b0, dma_req)
    apb(1'b1, udt_pkg::OFF_STOP, 32'h1);
    wait_ev(2, h + 2);
    `UDT_CHK("halt while idle", h + 2, ev[2])
    `UDT_CHK("no done while idle", d + 1, ev[1])
    $display("test stop done");
  endtask

  task automatic t_flow;
    int s;
    apb(1'b1, udt_pkg::OFF_CONFIG, 32'h1);
    hold <= 1'b1;
    xfer(32'hA0, 32'h3);
    repeat (400) @(posedge mclk);
    `UDT_CHK("paused count", b, rx_cnt)
    s = ev[0];
    hold <= 1'b0;
    wait_ev(0, s + 1);
    for (i = 0; i < 3000 && txd !== 1'b0; i++) @(posedge mclk);
    hold <= 1'b1;
    wait_ev(0, s + 2);
    repeat (400) @(posedge mclk);
    `UDT_CHK("char in flight", 8'(b + 2), rx_cnt)
    hold <= 1'b0;
    wait_ev(1, ev[1] + 1);
    chk_bytes(b, 32'hA0, 3);
    apb(1'b1, udt_pkg::OFF_CONFIG, 32'h0);
    hold <= 1'b1;
    xfer(32'hB0, 32'h1);
    wait_ev(1, ev[1] + 1);
    chk_bytes(b, 32'hB0, 1);
    hold <= 1'b0;
    $display("test flow control done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    finish_test;
  end

  initial begin
    mclk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; hold = 1'b0; par_en = 1'b0; two_stop = 1'b0;
    failures = 0; num_checks = 0; cyc = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_basic;
    t_parity;
    t_dbuf;
    t_stop;
    t_flow;
    finish_test;
  end
endmodule
